// *** logic/ued_top.sv ***
// in-endpoint descriptors, buffer ram, in-request engine and tx fifo
//
// Operation
// - x base forms address bits 10:3
// - y base forms address bits 10:3
// - start at base, never alter base
// - seven-bit linear byte count, 0 to 64
// - nak clear means ready, set answers nak
// - shared size field, top bit reads zero
// - ep 1-7 descriptors in ram, ep0 registers
// - ep0 buffers hardwired at fixed addresses
// - ep0 registers at fixed addresses
// - ep0 bits keep descriptor bit positions
// - double buffer: toggle picks x or y
// - serve only when enable bit set
//
// Implementation choice: the APB slave port.

// parameterised fifo with a registered output stage
module ued_fifo #(
  parameter int W = 9,
  parameter int D = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // fill side
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  // drain side
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  localparam int PW = $clog2(D);
  localparam int CW = $clog2(D + 1);
  localparam logic [CW-1:0] FULL = CW'(D);
  logic [W-1:0] mem [0:D-1]; // storage
  logic [PW-1:0] wr_q; // write pointer
  logic [PW-1:0] rd_q; // read pointer
  logic [CW-1:0] cnt_q; // words held in storage
  logic ov_q; // output stage valid
  logic [W-1:0] od_q; // output stage word
  logic push;
  logic pop;

  // full is honest: the output stage adds one more word of slack
  assign in_ready = (cnt_q != FULL);
  assign push = in_valid && in_ready;
  assign pop = (cnt_q != '0) && (!ov_q || out_ready);
  assign out_valid = ov_q;
  assign out_data = od_q;

  // storage write, no reset needed on data
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end

  // pointers and count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= PW'(wr_q + 1'b1);
      end
      if (pop) begin
        rd_q <= PW'(rd_q + 1'b1);
      end
      if (push && !pop) begin
        cnt_q <= CW'(cnt_q + 1'b1);
      end else if (pop && !push) begin
        cnt_q <= CW'(cnt_q - 1'b1);
      end
    end
  end

  // output stage keeps the drain side straight from flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ov_q <= 1'b0;
      od_q <= '0;
    end else if (pop) begin
      ov_q <= 1'b1;
      od_q <= mem[rd_q];
    end else if (out_ready) begin
      ov_q <= 1'b0;
    end
  end
endmodule : ued_fifo

// top: apb slave plus in-request engine
module ued_top
  import ued_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // host in request
  input wire logic in_req,
  input wire logic [2:0] in_ep,
  output logic in_nak,
  output logic in_stall,
  output logic in_done,
  // transmit byte stream
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic tx_last,
  input wire logic tx_ready
);
  // byte address of an indexed register
  function automatic logic [ADDR_W-1:0] idx_addr(input logic [15:0] idx);
    idx_addr = {idx, 2'b00};
  endfunction : idx_addr
  // clamp a seven-bit count, codes above 64 are undefined anyway
  function automatic logic [6:0] clamp_cnt(input logic [6:0] c);
    clamp_cnt = (c > MAX_CNT) ? MAX_CNT : c;
  endfunction : clamp_cnt
  // 11-bit buffer start from a base field
  function automatic logic [BUF_AW-1:0] base_addr(input logic [7:0] b);
    base_addr = {b, 3'b000};
  endfunction : base_addr
  logic [7:0] desc_q [1:7][0:N_FIELDS-1]; // descriptor entries
  logic [7:0] ep0_in_config_q; // endpoint 0 in config
  logic [7:0] ep0_in_byte_count_q; // endpoint 0 in count
  logic [7:0] ep0_out_config_q; // endpoint 0 out config
  logic [7:0] ep0_out_byte_count_q; // endpoint 0 out count
  logic [7:0] buf_mem [0:BUF_BYTES-1]; // packet buffer ram
  logic [BUF_AW-1:0] buf_ptr_q; // software window pointer
  logic pready_q; // access answer
  logic [31:0] prdata_q; // read data
  logic pslverr_q; // unmapped access
  ued_state_e state_q; // engine state
  logic [2:0] cur_ep_q; // endpoint being served
  logic cur_y_q; // y buffer in use
  logic [BUF_AW-1:0] rd_addr_q; // buffer read address
  logic [6:0] left_q; // bytes still to push
  logic done_q; // completion pulse
  logic nak_q; // nak answer pulse
  logic stall_q; // stall answer pulse
  logic fin; // transaction finishing this cycle
  logic fin_ep_y; // buffer finished
  logic [2:0] fin_ep; // endpoint finished
  // decode of the current apb address
  logic acc;
  logic commit;
  logic is_desc;
  logic [2:0] d_ep;
  logic [2:0] d_f;
  logic [31:0] rd_d;
  logic err_d;
  // selection for an incoming in request
  logic [7:0] s_cfg;
  logic s_y;
  logic [BUF_AW-1:0] s_base;
  logic [6:0] s_cnt;
  logic s_nak;
  // fifo fill side
  logic f_valid;
  logic f_ready;
  logic [FIFO_W-1:0] f_data;

  assign acc = psel && penable;
  assign commit = acc && pready_q; // write lands at the pready edge
  assign d_ep = paddr[7:5];
  assign d_f = paddr[4:2];
  assign is_desc = (paddr[ADDR_W-1:8] == '0) && (paddr[1:0] == 2'b00)
                   && (d_ep != 3'h0) && (d_f < 3'(N_FIELDS));
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign in_nak = nak_q;
  assign in_stall = stall_q;
  assign in_done = done_q;
  // read mux and unmapped detection
  always_comb begin
    rd_d = 32'h0000_0000;
    err_d = 1'b0;
    if (is_desc) begin
      rd_d[7:0] = desc_q[d_ep][d_f];
    end else if (paddr == idx_addr(IDX_EP0_IN_CFG)) begin
      rd_d[7:0] = ep0_in_config_q;
    end else if (paddr == idx_addr(IDX_EP0_IN_CNT)) begin
      rd_d[7:0] = ep0_in_byte_count_q;
    end else if (paddr == idx_addr(IDX_EP0_OUT_CFG)) begin
      rd_d[7:0] = ep0_out_config_q;
    end else if (paddr == idx_addr(IDX_EP0_OUT_CNT)) begin
      rd_d[7:0] = ep0_out_byte_count_q;
    end else if (paddr == A_BUF_ADDR) begin
      rd_d[BUF_AW-1:0] = buf_ptr_q;
    end else if (paddr == A_BUF_DATA) begin
      rd_d[7:0] = buf_mem[buf_ptr_q];
    end else if (paddr == A_STATUS) begin
      rd_d[0] = (state_q == ST_SEND);
      rd_d[6:4] = cur_ep_q;
      rd_d[8] = cur_y_q;
    end else begin
      err_d = 1'b1; // unmapped reads zero and errors
    end
  end

  // apb answer: one wait state, data held until the pready edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= acc && !pready_q;
      if (acc && !pready_q) begin
        prdata_q <= pwrite ? 32'h0000_0000 : rd_d;
        pslverr_q <= err_d;
      end else if (!acc) begin
        pslverr_q <= 1'b0;
      end
    end
  end

  // software window into the buffer ram, pointer auto-increments
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf_ptr_q <= '0;
    end else if (commit && pwrite && paddr == A_BUF_ADDR) begin
      buf_ptr_q <= pwdata[BUF_AW-1:0];
    end else if (commit && paddr == A_BUF_DATA) begin
      buf_ptr_q <= BUF_AW'(buf_ptr_q + 1'b1);
    end
  end
  // buffer ram write from software only; the engine just reads
  always_ff @(posedge pclk) begin
    if (commit && pwrite && paddr == A_BUF_DATA) begin
      buf_mem[buf_ptr_q] <= pwdata[7:0];
    end
  end
  // descriptor entries: software writes, then hardware nak and toggle;
  // hardware updates come last so a same-cycle set beats a clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int e = 1; e <= 7; e++) begin
        for (int f = 0; f < N_FIELDS; f++) begin
          desc_q[e][f] <= RST_ZERO;
        end
      end
    end else begin
      if (commit && pwrite && is_desc) begin
        case (d_f)
          F_SIZE: desc_q[d_ep][d_f] <= pwdata[7:0] & M_SIZE;
          F_CFG: desc_q[d_ep][d_f] <= pwdata[7:0] & M_CFG_N;
          default: desc_q[d_ep][d_f] <= pwdata[7:0];
        endcase
      end
      if (fin && fin_ep != 3'h0) begin
        if (fin_ep_y) begin
          desc_q[fin_ep][F_YCNT][B_NAK] <= 1'b1;
        end else begin
          desc_q[fin_ep][F_XCNT][B_NAK] <= 1'b1;
        end
        desc_q[fin_ep][F_CFG][B_TOG] <= ~desc_q[fin_ep][F_CFG][B_TOG];
      end
    end
  end

  // endpoint 0 registers, same bit positions as the descriptors
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ep0_in_config_q <= RST_ZERO;
      ep0_in_byte_count_q <= RST_CNT_0;
      ep0_out_config_q <= RST_ZERO;
      ep0_out_byte_count_q <= RST_CNT_0;
    end else begin
      if (commit && pwrite) begin
        if (paddr == idx_addr(IDX_EP0_IN_CFG)) begin
          ep0_in_config_q <= (pwdata[7:0] & M_CFG_0) | (ep0_in_config_q & ~M_CFG_0);
        end
        if (paddr == idx_addr(IDX_EP0_IN_CNT)) begin
          ep0_in_byte_count_q <= pwdata[7:0] & M_CNT_0;
        end
        if (paddr == idx_addr(IDX_EP0_OUT_CFG)) begin
          ep0_out_config_q <= (pwdata[7:0] & M_CFG_0) | (ep0_out_config_q & ~M_CFG_0);
        end
        if (paddr == idx_addr(IDX_EP0_OUT_CNT)) begin
          ep0_out_byte_count_q <= pwdata[7:0] & M_CNT_0;
        end
      end
      if (fin && fin_ep == 3'h0) begin
        ep0_in_byte_count_q[B_NAK] <= 1'b1;
        ep0_in_config_q[B_TOG] <= ~ep0_in_config_q[B_TOG];
      end
    end
  end

  // pick descriptor for the requested endpoint
  always_comb begin
    s_cfg = (in_ep == 3'h0) ? ep0_in_config_q : desc_q[in_ep][F_CFG];
    s_y = 1'b0;
    s_base = EP0_IN_BUF[BUF_AW-1:0];
    s_cnt = 7'h00;
    s_nak = 1'b1;
    if (in_ep == 3'h0) begin
      // ep0 has no double buffering; codes above 8 act as 8
      s_cnt = (ep0_in_byte_count_q[3:0] > MAX_CNT_0) ? {3'b000, MAX_CNT_0}
              : {3'b000, ep0_in_byte_count_q[3:0]};
      s_nak = ep0_in_byte_count_q[B_NAK];
    end else begin
      s_y = s_cfg[B_DOUBLE_BUFFER_ENABLE] && s_cfg[B_TOG];
      s_base = base_addr(s_y ? desc_q[in_ep][F_YBASE] : desc_q[in_ep][F_XBASE]);
      s_cnt = clamp_cnt(s_y ? desc_q[in_ep][F_YCNT][6:0] : desc_q[in_ep][F_XCNT][6:0]);
      s_nak = s_y ? desc_q[in_ep][F_YCNT][B_NAK] : desc_q[in_ep][F_XCNT][B_NAK];
    end
  end

  // a transaction ends on its last push, or at once when empty
  assign fin = ((state_q == ST_SEND) && f_ready && left_q == 7'h01)
               || (state_q == ST_IDLE && in_req && s_cfg[B_ENA]
                   && !s_cfg[B_STALL] && !s_nak && s_cnt == 7'h00);
  assign fin_ep = (state_q == ST_SEND) ? cur_ep_q : in_ep;
  assign fin_ep_y = (state_q == ST_SEND) ? cur_y_q : s_y;
  // in-request engine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      cur_ep_q <= 3'h0;
      cur_y_q <= 1'b0;
      rd_addr_q <= '0;
      left_q <= 7'h00;
    end else begin
      case (state_q)
        ST_IDLE: begin
          // disabled endpoints are not served at all
          if (in_req && s_cfg[B_ENA] && !s_cfg[B_STALL] && !s_nak
              && s_cnt != 7'h00) begin
            state_q <= ST_SEND;
            cur_ep_q <= in_ep;
            cur_y_q <= s_y;
            rd_addr_q <= s_base; // copy, base stays as written
            left_q <= s_cnt;
          end
        end
        ST_SEND: begin
          // fifo back-pressure stalls the read sequence
          if (f_ready) begin
            rd_addr_q <= BUF_AW'(rd_addr_q + 1'b1);
            left_q <= 7'(left_q - 1'b1);
            if (left_q == 7'h01) begin
              state_q <= ST_IDLE;
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // handshake pulses toward the protocol engine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_q <= 1'b0;
      nak_q <= 1'b0;
      stall_q <= 1'b0;
    end else begin
      done_q <= fin;
      nak_q <= (state_q == ST_IDLE) && in_req && s_cfg[B_ENA]
               && !s_cfg[B_STALL] && s_nak;
      stall_q <= (state_q == ST_IDLE) && in_req && s_cfg[B_ENA] && s_cfg[B_STALL];
    end
  end

  assign f_valid = (state_q == ST_SEND);
  assign f_data = {(left_q == 7'h01), buf_mem[rd_addr_q]};

  // transmit fifo
  ued_fifo #(
    .W(FIFO_W),
    .D(FIFO_D)
  ) u_fifo (
    .clk(pclk),
    .rst_n(presetn),
    .in_valid(f_valid),
    .in_data(f_data),
    .in_ready(f_ready),
    .out_valid(tx_valid),
    .out_data({tx_last, tx_data}),
    .out_ready(tx_ready)
  );
endmodule : ued_top

// *** logic/ued_pkg.sv ***
// constants and types shared by the in-endpoint descriptor block
package ued_pkg;
  // apb address width in bits, byte addresses
  localparam int ADDR_W = 18;
  // endpoint 0 register indices, byte address is four times these
  localparam logic [15:0] IDX_EP0_IN_CFG = 16'hFF80;
  localparam logic [15:0] IDX_EP0_IN_CNT = 16'hFF81;
  localparam logic [15:0] IDX_EP0_OUT_CFG = 16'hFF82;
  localparam logic [15:0] IDX_EP0_OUT_CNT = 16'hFF83;
  // descriptor block: byte address = endpoint * 32 + field * 4
  localparam logic [2:0] F_XBASE = 3'h0;
  localparam logic [2:0] F_XCNT = 3'h1;
  localparam logic [2:0] F_YBASE = 3'h2;
  localparam logic [2:0] F_YCNT = 3'h3;
  localparam logic [2:0] F_SIZE = 3'h4;
  localparam logic [2:0] F_CFG = 3'h5;
  localparam int N_FIELDS = 6;
  // buffer window and status registers
  localparam logic [ADDR_W-1:0] A_BUF_ADDR = 18'h00100;
  localparam logic [ADDR_W-1:0] A_BUF_DATA = 18'h00104;
  localparam logic [ADDR_W-1:0] A_STATUS = 18'h00108;
  // bit positions inside config and count bytes
  localparam int B_NAK = 7;
  localparam int B_ENA = 7;
  localparam int B_TOG = 5;
  localparam int B_DOUBLE_BUFFER_ENABLE = 4;
  localparam int B_STALL = 3;
  // writable masks
  localparam logic [7:0] M_CFG_N = 8'hFC;
  localparam logic [7:0] M_CFG_0 = 8'h8C;
  localparam logic [7:0] M_CNT_0 = 8'h8F;
  localparam logic [7:0] M_SIZE = 8'h7F;
  // reset values
  localparam logic [7:0] RST_CNT_0 = 8'h80;
  localparam logic [7:0] RST_ZERO = 8'h00;
  // byte count limits
  localparam logic [6:0] MAX_CNT = 7'h40;
  localparam logic [3:0] MAX_CNT_0 = 4'h8;
  // hardwired endpoint 0 buffer bases
  localparam logic [15:0] EP0_IN_BUF = 16'hFEF8;
  localparam logic [15:0] EP0_OUT_BUF = 16'hFEF0;
  // buffer ram
  localparam int BUF_AW = 11;
  localparam int BUF_BYTES = 2048;
  // transmit fifo shape: byte plus last flag
  localparam int FIFO_W = 9;
  localparam int FIFO_D = 8;
  // serving engine states
  typedef enum logic [0:0] {ST_IDLE, ST_SEND} ued_state_e;
endpackage : ued_pkg

// *** verif/ued_chk_sva.sv ***
// assertion checker for the in-endpoint descriptor top
module ued_chk
  import ued_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // host in request
  input wire logic in_req,
  input wire logic [2:0] in_ep,
  input wire logic in_nak,
  input wire logic in_stall,
  input wire logic in_done,
  // transmit stream
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  input wire logic tx_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // read answer from the endpoint 1..7 descriptor area
  logic desc_rd;
  assign desc_rd = pready && !pwrite && paddr[17:5] != 0 && paddr[17:5] < 13'h8;
  one_wait_a: assert property (psel && $rose(penable) |-> !pready ##1 pready)
    else $error("apb answer not after one wait state");
  size_top_a: assert property (desc_rd && paddr[4:0] == 5'h10 |-> !prdata[7])
    else $error("size top bit not zero");
  cfg0_rsv_a: assert property (pready && !pwrite && paddr == 18'h3FE00
    |-> (prdata & ~32'hAC) == 0) else $error("ep0 config reserved bits set");
  cnt0_rsv_a: assert property (pready && !pwrite && paddr == 18'h3FE04
    |-> (prdata & ~32'h8F) == 0) else $error("ep0 count reserved bits set");
  desc_map_a: assert property (desc_rd && paddr[4:2] < 3'h6 && paddr[1:0] == 0
    |-> !pslverr) else $error("descriptor field refused");
  err_zero_a: assert property (pready && pslverr |-> prdata == 32'h0)
    else $error("refused access returned data");
  nak_cause_a: assert property (in_nak |-> $past(in_req))
    else $error("nak without request");
  stall_cause_a: assert property (in_stall |-> $past(in_req))
    else $error("stall without request");
  one_answer_a: assert property ($onehot0({in_nak, in_stall, in_done}))
    else $error("two answers at once");
  tx_hold_a: assert property (tx_valid && !tx_ready |=>
    tx_valid && $stable(tx_data) && $stable(tx_last)) else $error("stalled byte changed");
  // main scenarios
  cover property (in_nak);
  cover property (in_stall);
  cover property (tx_valid && tx_ready && tx_last);
  cover property ((tx_valid && !tx_ready) [*8]);
endmodule : ued_chk

bind ued_top ued_chk chk_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .in_req(in_req), .in_ep(in_ep), .in_nak(in_nak), .in_stall(in_stall), .in_done(in_done),
  .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready)
);

// *** verif/ued_host.sv ***
// host model: issues in tokens and sinks the byte stream
module ued_host (
  // clock
  input wire logic clk,
  // token
  output logic in_req,
  output logic [2:0] in_ep,
  // stream sink
  output logic tx_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  int mode = 0; // 0 prompt, 1 random stalls, 2 long holds
  int hold_n = 0; // position in the hold pattern
  integer seed = 32'h89ba85bb; // fixed seed
  initial begin
    in_req = 1'b0;
    in_ep = 3'h0;
    tx_ready = 1'b1;
  end
  // ready pattern; long holds let the fifo fill until it refuses
  always @(posedge clk) begin
    hold_n <= (hold_n == 47) ? 0 : hold_n + 1;
    case (mode)
      0: tx_ready <= 1'b1;
      1: tx_ready <= ($random(seed) & 3) == 0;
      default: tx_ready <= hold_n > 40;
    endcase
  end
  // one-cycle token; caller waits for the answer before the next
  task automatic req(input logic [2:0] ep);
    in_ep <= ep;
    in_req <= 1'b1;
    @(posedge clk);
    in_req <= 1'b0;
    in_ep <= ~ep; // released: no stale endpoint left showing
  endtask : req
endmodule : ued_host

// *** verif/tb_top.sv ***
// self-checking bench for the in-endpoint descriptor top
module tb_top
  import ued_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // stimulus
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  // outputs
  logic [31:0] prdata;
  logic pready, pslverr, in_req, in_nak, in_stall, in_done, tx_valid, tx_last, tx_ready;
  logic [2:0] in_ep;
  logic [7:0] tx_data;
  // bookkeeping
  integer n_mismatch = 0;
  integer num_checks = 0;
  integer seed = 32'h89ba85bb;
  logic [32:0] exp_r[$]; // {slverr, data}
  logic [8:0] exp_b[$]; // {last, byte}
  logic [1:0] exp_e[$]; // 01 nak, 10 stall, 11 done
  logic [7:0] img [0:2047]; // copy of buffer ram
  always #2.5 pclk = ~pclk;
  ued_top dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .in_req(in_req), .in_ep(in_ep), .in_nak(in_nak), .in_stall(in_stall), .in_done(in_done),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready)
  );
  ued_host host_u (.clk(pclk), .in_req(in_req), .in_ep(in_ep), .tx_ready(tx_ready));
  // verdict and end of run
  task automatic report_and_stop;
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop
  task automatic bad(input string m);
    n_mismatch++;
    $display("BAD %0t %s", $time, m);
  endtask : bad
  // an empty queue yields x, which always counts as a mismatch
  task automatic cmp(input logic [32:0] g, input logic [32:0] e, input string m);
    num_checks++;
    if ($isunknown(e) || g !== e) bad(m);
  endtask : cmp
  task automatic chk_rd(input logic [32:0] g);
    cmp(g, exp_r.size() ? exp_r.pop_front() : 33'bx, "read answer");
  endtask : chk_rd
  task automatic chk_byte(input logic [8:0] g);
    cmp(33'(g), exp_b.size() ? 33'(exp_b.pop_front()) : 33'bx, "tx byte");
  endtask : chk_byte
  task automatic chk_evt(input logic [1:0] g);
    cmp(33'(g), exp_e.size() ? 33'(exp_e.pop_front()) : 33'bx, "in answer");
  endtask : chk_evt
  // monitor: values as sampled at the edge
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) chk_rd({pslverr, prdata});
    if (tx_valid && tx_ready) chk_byte({tx_last, tx_data});
    if (in_nak || in_stall || in_done) chk_evt({in_done | in_stall, in_done | in_nak});
  end
  // apb transfer: setup, then access held until pready
  task automatic apb(input logic w, input logic [17:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [17:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [17:0] a, input logic [32:0] e);
    exp_r.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : rd
  function automatic logic [17:0] da(input int n, input logic [2:0] f);
    return 18'(n * 32 + f * 4);
  endfunction : da
  // random bytes into buffer ram through the window
  task automatic fill(input int s, input int n);
    wr(A_BUF_ADDR, 32'(s));
    for (int i = 0; i < n; i++) begin
      img[s + i] = 8'($random(seed));
      wr(A_BUF_DATA, {24'h0, img[s + i]});
    end
  endtask : fill
  // one token, expected bytes and answer, then wait for the queues to drain
  task automatic serve(input logic [2:0] ep, input int s, input int n, input logic [1:0] ev);
    int t;
    for (int i = 0; i < n; i++) exp_b.push_back({i == n - 1, img[s + i]});
    if (ev != 2'b00) exp_e.push_back(ev);
    host_u.req(ep);
    t = 0;
    while ((exp_b.size() != 0 || exp_e.size() != 0) && t < 3000) begin
      @(posedge pclk);
      t++;
    end
    if (t == 3000) bad("no answer");
    repeat (4) @(posedge pclk);
  endtask : serve
  // hang guard
  initial begin
    repeat (40000) @(posedge pclk);
    bad("timeout");
    report_and_stop();
  end
  // main sequence
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd({IDX_EP0_IN_CNT, 2'b00}, {1'b0, 24'h0, RST_CNT_0});
    rd({IDX_EP0_OUT_CNT, 2'b00}, {1'b0, 24'h0, RST_CNT_0});
    rd({IDX_EP0_IN_CFG, 2'b00}, 33'h0);
    rd({IDX_EP0_OUT_CFG, 2'b00}, 33'h0);
    rd(da(3, F_XBASE), 33'h0);
    rd(18'h00038, {1'b1, 32'h0});
    wr(da(1, F_SIZE), 32'hFF);
    rd(da(1, F_SIZE), 33'h7F);
    wr({IDX_EP0_IN_CFG, 2'b00}, 32'hFF);
    rd({IDX_EP0_IN_CFG, 2'b00}, {1'b0, 24'h0, M_CFG_0});
    wr({IDX_EP0_OUT_CNT, 2'b00}, 32'hFF);
    rd({IDX_EP0_OUT_CNT, 2'b00}, {1'b0, 24'h0, M_CNT_0});
    // full 64-byte packet from x, far side holding off
    fill(32'h200, 64);
    wr(da(1, F_XBASE), 32'h40);
    wr(da(1, F_XCNT), 32'h40);
    wr(da(1, F_CFG), 32'h80);
    host_u.mode = 2;
    serve(3'h1, 32'h200, 64, 2'b11);
    rd(da(1, F_XCNT), 33'hC0);
    rd(da(1, F_XBASE), 33'h40);
    rd(da(1, F_CFG), 33'hA0);
    serve(3'h1, 0, 0, 2'b01);
    // double buffer with toggle set picks y; x decoy differs in count
    host_u.mode = 1;
    fill(32'h240, 5);
    wr(da(1, F_YBASE), 32'h48);
    wr(da(1, F_YCNT), 32'h05);
    wr(da(1, F_XCNT), 32'h03);
    wr(da(1, F_CFG), 32'hB0);
    serve(3'h1, 32'h240, 5, 2'b11);
    rd(da(1, F_YCNT), 33'h85);
    rd(da(1, F_XCNT), 33'h03);
    rd(A_STATUS, 33'h110);
    // zero count, stall, disabled endpoint
    wr(da(2, F_XCNT), 32'h0);
    wr(da(2, F_CFG), 32'h80);
    serve(3'h2, 0, 0, 2'b11);
    wr(da(3, F_CFG), 32'h88);
    serve(3'h3, 0, 0, 2'b10);
    serve(3'h4, 0, 0, 2'b00);
    // endpoint 0 from its hardwired buffer
    fill(32'h6F8, 8);
    wr({IDX_EP0_IN_CNT, 2'b00}, 32'h08);
    wr({IDX_EP0_IN_CFG, 2'b00}, 32'h80);
    serve(3'h0, 32'h6F8, 8, 2'b11);
    rd({IDX_EP0_IN_CNT, 2'b00}, {1'b0, 24'h0, 8'h88});
    // window read back of the hardwired ep0 buffer, pointer steps after the read
    wr(A_BUF_ADDR, 32'h6F8);
    rd(A_BUF_DATA, {1'b0, 24'h0, img[32'h6F8]});
    rd(A_BUF_ADDR, 33'h6F9);
    report_and_stop();
  end
endmodule : tb_top
